// >>> soak_pkg.sv
// Functional notes
// - Launch idle-to-active begins the program
// - Soak elapsed in band raises completion
// - Pattern selects stop or continue after done
// - Pattern off disables all program operation
// - Stop pattern halts control at completion
// - Continue pattern keeps run mode at completion
// - Timer counts only inside set point band
// - Band off means count continuously
// - Band accepts off or 1 to 9999 counts
// - Start from launch setting or owned event
// - Communications start only without event ownership
// - Event ownership makes launch setting read-only
// - Pattern off clears event start ownership
// - Done display alternates end text every 0.5 s
// - Pattern enable routes completion to aux 1
// - Pattern disable restores alarm 1 assignment
// - Compact heat/cool skips automatic aux routing
// - Launch active-to-idle clears completion and display
// - Event clears done; key clear refused then
// - Completion assignable and visible in status
// - Start enters run, early reset enters stop
// - Soak keeps counting while control stopped
package soak_pkg;
    localparam int CLK_HZ   = 50_000_000;
    localparam int BLINK_MS = 500;
    localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
    localparam int TICK_S   = 1;
    localparam int TICK_CYC = TICK_S * CLK_HZ;
    localparam int MIN_SEC  = 60;
    localparam int HOUR_SEC = 3600;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] SOAK_OFS   = 8'h04;
    localparam logic [7:0] BAND_OFS   = 8'h08;
    localparam logic [7:0] STAT_OFS   = 8'h0c;
    localparam logic [7:0] REMAIN_OFS = 8'h10;
    localparam logic [7:0] OSEL_OFS   = 8'h14;
    // Control and output select field positions
    localparam int CTRL_PAT    = 0;
    localparam int CTRL_LAUNCH = 2;
    localparam int CTRL_UNIT   = 3;
    localparam int CTRL_HC     = 4;
    localparam int CTRL_COMPACT = 5;
    localparam int CTRL_EVOWN  = 6;
    localparam int CTRL_ANALOG = 7;
    localparam int CTRL_RUN    = 8;
    localparam int OSEL_AUX1   = 0;
    localparam int OSEL_FIRST_ALARM_FUNCTION   = 2;
    // Limits and reset values
    localparam logic [13:0] SOAK_MIN = 14'h0001;
    localparam logic [13:0] SOAK_MAX = 14'h270f;
    localparam logic [13:0] BAND_MAX = 14'h270f;
    localparam logic [13:0] SOAK_RST = 14'h0001;
    localparam logic [13:0] BAND_RST = 14'h0000;

    typedef enum logic [1:0] {PAT_OFF, PAT_STOP, PAT_CONTINUE_AFTER_DONE} pattern_e;
    typedef enum logic [1:0] {SEL_NONE, SEL_ALARM, SEL_END} osel_e;
    typedef enum logic [1:0] {PROG_IDLE, PROG_SOAK, PROG_DONE} prog_e;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_s;
endpackage

// >>> soak_program_sequencer.sv
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module soak_program_sequencer
    import soak_pkg::*;
#(
    parameter int TICK_CYCLES  = TICK_CYC,
    parameter int BLINK_CYCLES = BLINK_CYC
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire wb_req_s            wb_req,
    output var  logic [31:0]        wb_dat_o,
    output var  logic               wb_ack_o,
    input  wire logic               event_in,
    input  wire logic               comm_start,
    input  wire logic               comm_reset,
    input  wire logic signed [15:0] pv,
    input  wire logic signed [15:0] sp,
    input  wire logic               alarm1_in,
    output var  logic               done_out,
    output var  logic               aux1_out,
    output var  logic               first_alarm_function_out,
    output var  logic               run_mode,
    output var  logic               disp2_end
);
    pattern_e    pattern;
    pattern_e    pat_q;
    osel_e       aux1_sel;
    osel_e       first_alarm_function_sel;
    prog_e       state;
    prog_e       next_state;
    logic        launch;
    logic        launch_q;
    logic        unit_h;
    logic        heat_cool;
    logic        compact;
    logic        ev_own;
    logic        analog;
    logic [13:0] soak;
    logic [13:0] band;
    logic [31:0] pre_cnt;
    logic [11:0] sec_cnt;
    logic [13:0] elapsed;
    logic [31:0] blink_cnt;
    logic [31:0] rdata;
    logic [15:0] wmerge;
    logic [16:0] diff;
    logic [16:0] adiff;
    logic        in_band;
    logic        req;
    logic        wr;
    logic        wr_ctrl;
    logic        start;
    logic        stop;
    logic        finish;
    logic        sec_tick;
    logic        unit_tick;

    // Bus request decode; answer one cycle after the request is seen
    assign req     = wb_req.cyc & wb_req.stb & ~wb_ack_o;
    assign wr      = req & wb_req.we;
    assign wr_ctrl = wr & (wb_req.adr == CTRL_OFS) & wb_req.sel[0];

    // Low half-word write with byte lanes
    always_comb begin
        wmerge = (wb_req.adr == SOAK_OFS) ? {2'b00, soak} : {2'b00, band};
        if (wb_req.sel[0]) begin
            wmerge[7:0] = wb_req.dat[7:0];
        end
        if (wb_req.sel[1]) begin
            wmerge[15:8] = wb_req.dat[15:8];
        end
    end

    // Launch edges drive the sequencer
    assign start  = launch & ~launch_q;
    assign stop   = ~launch & launch_q;
    assign finish = (state == PROG_SOAK) & ~stop & (elapsed >= soak);

    // Band check in 17 bits so the difference cannot wrap
    assign diff    = {pv[15], pv} - {sp[15], sp};
    assign adiff   = diff[16] ? 17'(-diff) : diff;
    assign in_band = (band == 14'h0000) | (adiff <= {3'b000, band});

    // Prescaler ticks; counting ignores run mode on purpose
    assign sec_tick  = (pre_cnt == 32'(TICK_CYCLES - 1));
    assign unit_tick = sec_tick
        & (sec_cnt == (unit_h ? 12'(HOUR_SEC - 1) : 12'(MIN_SEC - 1)));

    // Configuration bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pattern   <= PAT_OFF;
            unit_h    <= 1'b0;
            heat_cool <= 1'b0;
            compact   <= 1'b0;
            ev_own    <= 1'b0;
            analog    <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                if (wb_req.dat[CTRL_PAT +: 2] != 2'b11) begin
                    pattern <= pattern_e'(wb_req.dat[CTRL_PAT +: 2]);
                end
                unit_h    <= wb_req.dat[CTRL_UNIT];
                heat_cool <= wb_req.dat[CTRL_HC];
                compact   <= wb_req.dat[CTRL_COMPACT];
                ev_own    <= wb_req.dat[CTRL_EVOWN];
                analog    <= wb_req.dat[CTRL_ANALOG];
            end
            if (pattern == PAT_OFF) begin
                ev_own <= 1'b0;
            end
        end
    end

    // Soak duration and wait band; out-of-range values are refused
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            soak <= SOAK_RST;
            band <= BAND_RST;
        end else if (wr && wmerge[15:14] == 2'b00) begin
            if (wb_req.adr == SOAK_OFS && wmerge[13:0] >= SOAK_MIN
                    && wmerge[13:0] <= SOAK_MAX) begin
                soak <= wmerge[13:0];
            end
            if (wb_req.adr == BAND_OFS && wmerge[13:0] <= BAND_MAX) begin
                band <= wmerge[13:0];
            end
        end
    end

    // Launch setting: an owning event overrides keys and comms
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            launch   <= 1'b0;
            launch_q <= 1'b0;
        end else begin
            launch_q <= launch;
            if (pattern == PAT_OFF) begin
                launch <= 1'b0;
            end else if (ev_own) begin
                launch <= event_in;
            end else if (comm_start) begin
                launch <= 1'b1;
            end else if (comm_reset) begin
                launch <= 1'b0;
            end else if (wr_ctrl) begin
                launch <= wb_req.dat[CTRL_LAUNCH];
            end
        end
    end

    // Program sequence
    always_comb begin
        next_state = state;
        case (state)
            PROG_IDLE: begin
                if (start) begin
                    next_state = PROG_SOAK;
                end
            end
            PROG_SOAK: begin
                if (stop) begin
                    next_state = PROG_IDLE;
                end else if (finish) begin
                    next_state = PROG_DONE;
                end
            end
            PROG_DONE: begin
                if (stop) begin
                    next_state = PROG_IDLE;
                end
            end
            default: next_state = PROG_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= PROG_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Soak timer; holds while out of band, clears when idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_cnt <= 32'h0000_0000;
            sec_cnt <= 12'h000;
            elapsed <= 14'h0000;
        end else if (state != PROG_SOAK || stop) begin
            pre_cnt <= 32'h0000_0000;
            sec_cnt <= 12'h000;
            elapsed <= 14'h0000;
        end else if (in_band && !finish) begin
            pre_cnt <= sec_tick ? 32'h0000_0000 : pre_cnt + 32'h0000_0001;
            if (unit_tick) begin
                sec_cnt <= 12'h000;
                elapsed <= elapsed + 14'h0001;
            end else if (sec_tick) begin
                sec_cnt <= sec_cnt + 12'h001;
            end
        end
    end

    // Run/stop: start runs, early reset stops, done follows the pattern
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_mode <= 1'b0;
        end else if (state == PROG_IDLE && start) begin
            run_mode <= 1'b1;
        end else if (state == PROG_SOAK && stop) begin
            run_mode <= 1'b0;
        end else if (finish && pattern == PAT_STOP) begin
            run_mode <= 1'b0;
        end else if (finish) begin
            run_mode <= run_mode;
        end else if (wr && wb_req.adr == CTRL_OFS && wb_req.sel[1]) begin
            run_mode <= wb_req.dat[CTRL_RUN];
        end
    end

    // Completion flag and alternating second display
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_out  <= 1'b0;
            disp2_end <= 1'b0;
            blink_cnt <= 32'h0000_0000;
        end else begin
            done_out <= (next_state == PROG_DONE);
            if (next_state != PROG_DONE) begin
                disp2_end <= 1'b0;
                blink_cnt <= 32'h0000_0000;
            end else if (state != PROG_DONE) begin
                disp2_end <= 1'b1;
            end else if (blink_cnt == 32'(BLINK_CYCLES - 1)) begin
                disp2_end <= ~disp2_end;
                blink_cnt <= 32'h0000_0000;
            end else begin
                blink_cnt <= blink_cnt + 32'h0000_0001;
            end
        end
    end

    // Output assignment, rewritten on pattern enable and disable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pat_q    <= PAT_OFF;
            aux1_sel <= SEL_NONE;
            first_alarm_function_sel <= SEL_ALARM;
        end else begin
            pat_q <= pattern;
            if (wr && wb_req.adr == OSEL_OFS && wb_req.sel[0]) begin
                if (wb_req.dat[OSEL_AUX1 +: 2] != 2'b11) begin
                    aux1_sel <= osel_e'(wb_req.dat[OSEL_AUX1 +: 2]);
                end
                if (wb_req.dat[OSEL_FIRST_ALARM_FUNCTION +: 2] != 2'b11) begin
                    first_alarm_function_sel <= osel_e'(wb_req.dat[OSEL_FIRST_ALARM_FUNCTION +: 2]);
                end
            end
            if (pat_q == PAT_OFF && pattern != PAT_OFF && !(compact && heat_cool)) begin
                aux1_sel <= SEL_END;
            end
            if (pat_q != PAT_OFF && pattern == PAT_OFF) begin
                first_alarm_function_sel <= SEL_ALARM;
            end
        end
    end

    // Physical outputs follow their assignment
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aux1_out <= 1'b0;
            first_alarm_function_out <= 1'b0;
        end else begin
            aux1_out <= (aux1_sel == SEL_END) ? done_out : (aux1_sel == SEL_ALARM) & alarm1_in;
            first_alarm_function_out <= (first_alarm_function_sel == SEL_END) ? done_out : (first_alarm_function_sel == SEL_ALARM) & alarm1_in;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdata = 32'h0000_0000;
        case (wb_req.adr)
            CTRL_OFS: begin
                rdata[CTRL_PAT +: 2] = pattern;
                rdata[CTRL_LAUNCH]   = launch;
                rdata[CTRL_UNIT]     = unit_h;
                rdata[CTRL_HC]       = heat_cool;
                rdata[CTRL_COMPACT]  = compact;
                rdata[CTRL_EVOWN]    = ev_own;
                rdata[CTRL_ANALOG]   = analog;
                rdata[CTRL_RUN]      = run_mode;
            end
            SOAK_OFS: rdata[13:0] = soak;
            BAND_OFS: rdata[13:0] = band;
            STAT_OFS: rdata[5:0] = {in_band, disp2_end, launch, run_mode, done_out,
                                    state == PROG_SOAK};
            REMAIN_OFS: rdata[13:0] = (elapsed >= soak) ? 14'h0000 : soak - elapsed;
            OSEL_OFS: rdata[3:0] = {first_alarm_function_sel, aux1_sel};
            default: rdata = 32'h0000_0000;
        endcase
    end

    // Bus answer, dropped the cycle after it is given
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (req) begin
                wb_dat_o <= rdata;
            end
        end
    end

    // Sequencer, timer and routing checks; all on the one system clock
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    start_run_a: assert property (state == PROG_IDLE && start
        |=> state == PROG_SOAK && run_mode) else $error("start did not enter soak");
    done_set_a: assert property (finish
        |=> done_out ##1 (done_out || $past(stop)))
        else $error("completion not raised");
    stop_pat_a: assert property (finish && pattern == PAT_STOP |=> !run_mode)
        else $error("stop pattern kept running");
    continue_after_done_pat_a: assert property (finish && pattern == PAT_CONTINUE_AFTER_DONE && run_mode
        |=> run_mode) else $error("continue pattern stopped");
    off_idle_a: assert property (pattern == PAT_OFF [*3] |-> state == PROG_IDLE)
        else $error("program active while pattern off");
    band_hold_a: assert property (state == PROG_SOAK && !in_band && !stop
        |=> $stable(pre_cnt) && $stable(elapsed)) else $error("timer ran out of band");
    band_off_a: assert property (band == 14'h0000 && state == PROG_SOAK && !stop && !finish
        |=> pre_cnt != $past(pre_cnt)) else $error("timer paused with band off");
    done_clear_a: assert property (state == PROG_DONE && stop
        |=> !done_out && !disp2_end && state == PROG_IDLE) else $error("done not cleared");
    event_own_a: assert property (ev_own && pattern != PAT_OFF
        |=> launch == $past(event_in)) else $error("launch ignored owning event");
    comm_block_a: assert property (ev_own && pattern != PAT_OFF && comm_start && !event_in
        |=> !launch) else $error("comm start accepted with event owner");
    aux_route_a: assert property (pat_q == PAT_OFF && pattern != PAT_OFF
        && !(compact && heat_cool) |=> aux1_sel == SEL_END) else $error("aux 1 not routed");
    alm_restore_a: assert property (pat_q != PAT_OFF && pattern == PAT_OFF
        |=> first_alarm_function_sel == SEL_ALARM) else $error("alarm 1 not restored");
    blink_a: assert property (state == PROG_DONE && !stop
        && blink_cnt == 32'(BLINK_CYCLES - 1) |=> disp2_end != $past(disp2_end))
        else $error("display did not alternate");
    ev_clear_a: assert property (pattern == PAT_OFF |=> !ev_own)
        else $error("event ownership kept with pattern off");
    early_stop_a: assert property (state == PROG_SOAK && stop
        |=> state == PROG_IDLE && !run_mode) else $error("early reset kept running");
    idle_clear_a: assert property (state == PROG_IDLE |-> elapsed == 14'h0000)
        else $error("soak time kept while idle");
    unit_step_a: assert property (state == PROG_SOAK && !stop && !unit_tick
        |=> $stable(elapsed)) else $error("soak time stepped between units");
    aux_follow_a: assert property (aux1_sel == SEL_END
        |=> aux1_out == $past(done_out)) else $error("aux 1 did not follow completion");
    comp_skip_a: assert property (pat_q == PAT_OFF && pattern != PAT_OFF
        && compact && heat_cool && !wr |=> $stable(aux1_sel))
        else $error("aux 1 routed on compact heat/cool");
    key_launch_a: assert property (wr_ctrl && pattern != PAT_OFF && !ev_own
        && !comm_start && !comm_reset |=> launch == $past(wb_req.dat[CTRL_LAUNCH]))
        else $error("key launch write not taken");

    // Main scenarios reached
    start_c: cover property (state == PROG_IDLE && start);
    early_reset_c: cover property (state == PROG_SOAK && stop);
    finish_c: cover property (finish ##1 done_out);
    blink_c: cover property (state == PROG_DONE && disp2_end ##1 !disp2_end);
    event_start_c: cover property (ev_own && start);
endmodule
`default_nettype wire

// >>> panel_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module panel_host_model #(
    parameter int WRITE_LIMIT = 1_000_000
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic want_event,
    input  wire logic want_start,
    input  wire logic want_reset,
    output var  logic event_in,
    output var  logic comm_start,
    output var  logic comm_reset
);
    logic last_start;
    logic last_reset;
    int   launches;

    // Switch level passes through; command keys become one-cycle pulses
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            event_in   <= 1'b0;
            comm_start <= 1'b0;
            comm_reset <= 1'b0;
            last_start <= 1'b0;
            last_reset <= 1'b0;
        end else begin
            event_in   <= want_event;
            comm_start <= want_start & ~last_start;
            comm_reset <= want_reset & ~last_reset;
            last_start <= want_start;
            last_reset <= want_reset;
        end
    end

    // Host counts start/reset traffic and reports when it passes store endurance
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            launches <= 0;
        end else if (comm_start || comm_reset) begin
            launches <= launches + 1;
            if (launches >= WRITE_LIMIT) begin
                $display("Error at %0t: too many launch writes", $time);
            end
        end
    end
endmodule
`default_nettype wire

// >>> soak_program_sequencer_test.sv
`timescale 1ns/1ns
`default_nettype none
module soak_program_sequencer_test import soak_pkg::*;;
    localparam int TICK  = 4;
    localparam int BLINK = 8;
    typedef struct packed {
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
        logic [31:0] exp;
    } row_s;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    wb_req_s            wb_req = '0;
    logic [31:0]        wb_dat_o;
    logic               wb_ack_o, event_in, comm_start, comm_reset;
    logic               done_out, aux1_out, first_alarm_function_out, run_mode, disp2_end;
    logic               want_event = 1'b0, want_start = 1'b0, want_reset = 1'b0;
    logic               alarm1_in = 1'b0, prev;
    logic signed [15:0] pv = 16'sh0000, sp = 16'sh0064;
    int                 num_errors = 0, tests_run = 0, cycles = 0, n, toggles;
    // Register rows: optional write, then read-back against expected value
    row_s rows [15] = '{
        '{1'b0, CTRL_OFS, 4'hf, 32'h0, 32'h0}, '{1'b0, SOAK_OFS, 4'hf, 32'h0, 32'h1},
        '{1'b0, BAND_OFS, 4'hf, 32'h0, 32'h0}, '{1'b0, STAT_OFS, 4'hf, 32'h0, 32'h20},
        '{1'b0, OSEL_OFS, 4'hf, 32'h0, 32'h4}, '{1'b1, 8'h18, 4'hf, 32'hdead, 32'h0},
        '{1'b1, SOAK_OFS, 4'h3, 32'h0, 32'h1}, '{1'b1, SOAK_OFS, 4'h3, 32'h2710, 32'h1},
        '{1'b1, SOAK_OFS, 4'h3, 32'h270f, 32'h270f}, '{1'b1, BAND_OFS, 4'h3, 32'h2710, 32'h0},
        '{1'b1, BAND_OFS, 4'h3, 32'h3, 32'h3}, '{1'b1, CTRL_OFS, 4'h1, 32'h4, 32'h0},
        '{1'b1, OSEL_OFS, 4'h1, 32'h7, 32'h4}, '{1'b1, SOAK_OFS, 4'h3, 32'h2, 32'h2},
        '{1'b0, REMAIN_OFS, 4'hf, 32'h0, 32'h2}};

    soak_program_sequencer #(.TICK_CYCLES(TICK), .BLINK_CYCLES(BLINK)) dut (
        .clk(clk), .rst(rst), .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .event_in(event_in), .comm_start(comm_start), .comm_reset(comm_reset),
        .pv(pv), .sp(sp), .alarm1_in(alarm1_in), .done_out(done_out),
        .aux1_out(aux1_out), .first_alarm_function_out(first_alarm_function_out), .run_mode(run_mode),
        .disp2_end(disp2_end));
    panel_host_model host (
        .clk(clk), .rst(rst), .want_event(want_event), .want_start(want_start),
        .want_reset(want_reset), .event_in(event_in), .comm_start(comm_start),
        .comm_reset(comm_reset));

    always #10 clk = ~clk;
    // Hang guard, sized well past the hour-unit soak
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask
    // One classic cycle; held until ack is sampled, then released
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                            input logic [31:0] dat, output logic [31:0] rd);
        @(posedge clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
        @(posedge clk);
        // Wait on ack for as long as it takes; the hang guard ends a dead bus
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk);
        end
        rd = wb_dat_o;
        wb_req <= '0;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
        logic [31:0] d;
        wb_cycle(1'b1, adr, sel, dat, d);
    endtask
    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        wb_cycle(1'b0, adr, 4'hf, 32'h0, d);
        check_word(d, exp);
    endtask
    task automatic wait_done(input int max, output int k);
        k = 0;
        while (done_out !== 1'b1 && k < max) begin
            @(posedge clk);
            k++;
        end
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].we) wr(rows[i].adr, rows[i].sel, rows[i].dat);
            rd_chk(rows[i].adr, rows[i].exp);
        end
        // Stop pattern: auto routing, then an early reset and a paused soak
        wr(CTRL_OFS, 4'h1, 32'h1);
        rd_chk(OSEL_OFS, 32'h6);
        alarm1_in <= 1'b1;
        repeat (3) @(posedge clk);
        check_bit(first_alarm_function_out, 1'b1);
        alarm1_in <= 1'b0;
        pv <= 16'sh0067;
        wr(CTRL_OFS, 4'h1, 32'h5);
        repeat (3) @(posedge clk);
        check_bit(run_mode, 1'b1);
        repeat (300) @(posedge clk);
        wr(CTRL_OFS, 4'h1, 32'h1);
        repeat (3) @(posedge clk);
        check_bit(run_mode, 1'b0);
        wr(CTRL_OFS, 4'h1, 32'h5);
        repeat (400) @(posedge clk);
        check_bit(done_out, 1'b0);
        wr(CTRL_OFS, 4'h2, 32'h0);
        check_bit(run_mode, 1'b0);
        repeat (40) @(posedge clk);
        pv <= 16'sh00c8;
        repeat (100) @(posedge clk);
        check_bit(done_out, 1'b0);
        rd_chk(REMAIN_OFS, 32'h1);
        pv <= 16'sh0067;
        wr(CTRL_OFS, 4'h2, 32'h100);
        wait_done(150, n);
        check_bit(done_out, 1'b1);
        check_bit(n >= 15 && n <= 60, 1'b1);
        @(posedge clk);
        check_bit(run_mode, 1'b0);
        @(posedge clk);
        check_bit(aux1_out, 1'b1);
        rd_chk(STAT_OFS, 32'h3a);
        toggles = 0;
        prev = disp2_end;
        repeat (64) begin
            @(posedge clk);
            if (disp2_end !== prev) toggles++;
            prev = disp2_end;
        end
        check_bit(toggles == 64 / BLINK, 1'b1);
        wr(CTRL_OFS, 4'h1, 32'h1);
        repeat (3) @(posedge clk);
        check_bit(done_out | disp2_end | aux1_out, 1'b0);
        // Continue pattern, hour unit, band off, communications start
        wr(CTRL_OFS, 4'h1, 32'h0a);
        wr(BAND_OFS, 4'h3, 32'h0);
        wr(SOAK_OFS, 4'h3, 32'h1);
        pv <= 16'sh0384;
        want_start <= 1'b1;
        repeat (6) @(posedge clk);
        check_bit(run_mode, 1'b1);
        want_start <= 1'b0;
        repeat (HOUR_SEC * TICK - 500) @(posedge clk);
        check_bit(done_out, 1'b0);
        wait_done(800, n);
        check_bit(done_out, 1'b1);
        check_bit(run_mode, 1'b1);
        want_reset <= 1'b1;
        repeat (6) @(posedge clk);
        check_bit(done_out, 1'b0);
        want_reset <= 1'b0;
        // Event owns launch: key and command refused, event clears done
        wr(SOAK_OFS, 4'h3, 32'h1);
        wr(CTRL_OFS, 4'h1, 32'h42);
        want_event <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(CTRL_OFS, 32'h146);
        wr(CTRL_OFS, 4'h1, 32'h42);
        want_reset <= 1'b1;
        repeat (6) @(posedge clk);
        rd_chk(CTRL_OFS, 32'h146);
        wait_done(300, n);
        check_bit(done_out, 1'b1);
        want_event <= 1'b0;
        want_start <= 1'b1;
        repeat (4) @(posedge clk);
        check_bit(done_out, 1'b0);
        rd_chk(CTRL_OFS, 32'h142);
        wr(OSEL_OFS, 4'h1, 32'h2);
        wr(CTRL_OFS, 4'h1, 32'h40);
        rd_chk(CTRL_OFS, 32'h100);
        rd_chk(OSEL_OFS, 32'h6);
        // Compact heat/cool: enabling a pattern leaves outputs unassigned
        wr(CTRL_OFS, 4'h1, 32'h30);
        wr(OSEL_OFS, 4'h1, 32'h0);
        wr(CTRL_OFS, 4'h1, 32'h31);
        rd_chk(OSEL_OFS, 32'h0);
        // Mid-run reset returns every setting to its power-up value
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        check_bit(run_mode | aux1_out | first_alarm_function_out, 1'b0);
        rst <= 1'b0;
        rd_chk(CTRL_OFS, 32'h0);
        rd_chk(OSEL_OFS, 32'h4);
        finish_test();
    end
endmodule
`default_nettype wire
